// ==== hw/touch_panel_host_port_irq.sv ====
// Touch panel controller digital core: host port, sequencer and interrupt.
`timescale 1ns/10ps
module touch_panel_host_port_irq
  import touch_pkg::*;
#(
  parameter int REF_DIV = (CLK_HZ + REF_HZ / 2) / REF_HZ
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        chip_sel_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        reg_addr_bit0,
  input  wire logic        reg_addr_bit1,
  input  wire logic        reg_addr_bit2,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  input  wire logic        panel_touched,
  input  wire logic [11:0] adc_sample,
  output logic             adc_start,
  output logic             drive_x,
  output logic             drive_y,
  output logic             irq,
  output logic             touch_n
);
  localparam int DIVW = $clog2(REF_DIV + 1);
  localparam int IGW  = $clog2(IRQ_GEN_CYCLES + 1);

  function automatic logic [23:0] point_period(input logic [7:0] count);
    point_period = 24'(RATE_BASE) + 24'(RATE_STEP) * {16'h0000, count};
  endfunction : point_period

  logic [2:0]  addr;
  logic        rd_act;
  logic        wr_act;
  logic        rd_prev;
  logic        wr_prev;
  logic        rd_start;
  logic        wr_start;
  logic [7:0]  status;
  logic [7:0]  control;
  logic [7:0]  rate;
  logic [11:0] x_res;
  logic [11:0] y_res;
  logic [11:0] x_new;
  logic [11:0] y_new;
  logic        new_pending;
  logic [DIVW-1:0] ref_div;
  logic        ref_tick;
  logic [23:0] ref_count;
  logic [7:0]  conv_count;
  seq_state_t  state;
  logic        irq_event;
  logic [IGW-1:0] irq_gen;
  logic        touched_prev;

  assign addr     = {reg_addr_bit2, reg_addr_bit1, reg_addr_bit0};
  assign rd_act   = !chip_sel_n && !rd_n;
  assign wr_act   = !chip_sel_n && !wr_n;
  assign rd_start = rd_act && !rd_prev;
  assign wr_start = wr_act && !wr_prev;
  assign data_oe  = rd_act;
  assign touch_n  = !panel_touched;
  assign drive_x  = (state == ST_CONV_X);
  assign drive_y  = (state == ST_CONV_Y);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      touched_prev <= 1'b0;
    end else begin
      rd_prev <= rd_act;
      wr_prev <= wr_act;
      touched_prev <= panel_touched;
    end
  end

  // Read data is registered; it follows the addressed register every cycle of the read.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_out <= 8'h00;
    end else begin
      unique case (addr)
        REG_STATUS:  data_out <= status;
        REG_X_LOW:   data_out <= x_res[7:0];
        REG_X_HIGH:  data_out <= {4'h0, x_res[11:8]};
        REG_Y_LOW:   data_out <= y_res[7:0];
        REG_Y_HIGH:  data_out <= {4'h0, y_res[11:8]};
        REG_CONTROL: data_out <= control;
        REG_RATE:    data_out <= rate;
        default:     data_out <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control <= 8'h00;
      rate    <= RATE_RESET;
    end else if (wr_start) begin
      if (addr == REG_CONTROL) begin
        control <= data_in;
      end
      if (addr == REG_RATE) begin
        rate <= (data_in < RATE_MIN) ? RATE_MIN : data_in;
      end
    end
  end

  assign status = {5'h00, state != ST_SLEEP, panel_touched, new_pending};

  // Reference clock tick derived from the system clock stands in for the input reference.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ref_div <= '0;
      ref_tick <= 1'b0;
    end else if (ref_div == DIVW'(REF_DIV - 1)) begin
      ref_div <= '0;
      ref_tick <= 1'b1;
    end else begin
      ref_div <= ref_div + 1'b1;
      ref_tick <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state      <= ST_SLEEP;
      ref_count  <= '0;
      conv_count <= '0;
      adc_start  <= 1'b0;
      x_new      <= '0;
      y_new      <= '0;
      new_pending <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      if (new_pending && !rd_act) begin
        new_pending <= 1'b0;
      end
      if (ref_tick) begin
        ref_count <= ref_count + 1'b1;
      end
      unique case (state)
        ST_SLEEP: begin
          ref_count <= '0;
          if (panel_touched && control[CTL_POWER_UP] && control[CTL_PERIODIC]) begin
            state <= ST_CONV_X;
            conv_count <= '0;
            adc_start <= 1'b1;
          end
        end
        ST_CONV_X: begin
          if (ref_tick) conv_count <= conv_count + 1'b1;
          if (ref_tick && conv_count == 8'(CONV_CYCLES - 1)) begin
            x_new <= adc_sample;
            conv_count <= '0;
            adc_start <= 1'b1;
            state <= ST_CONV_Y;
          end
        end
        ST_CONV_Y: begin
          if (ref_tick) conv_count <= conv_count + 1'b1;
          if (ref_tick && conv_count == 8'(CONV_CYCLES - 1)) begin
            y_new <= adc_sample;
            new_pending <= 1'b1;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!control[CTL_POWER_UP] || !panel_touched) begin
            state <= ST_SLEEP;
          end else if (ref_tick && ref_count >= point_period(rate) - 24'h1) begin
            ref_count <= '0;
            conv_count <= '0;
            adc_start <= 1'b1;
            state <= ST_CONV_X;
          end
        end
        default: state <= ST_SLEEP;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      x_res <= '0;
      y_res <= '0;
    end else if (new_pending && !rd_act) begin
      x_res <= x_new;
      y_res <= y_new;
    end
  end

  assign irq_event = (new_pending && !rd_act && control[CTL_IRQ_CONV])
                   || (panel_touched != touched_prev && control[CTL_IRQ_TOUCH]);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_gen <= '0;
    end else if (irq_event) begin
      irq_gen <= IGW'(IRQ_GEN_CYCLES);
    end else if (irq_gen != '0) begin
      irq_gen <= irq_gen - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (irq_event) begin
      irq <= 1'b1;
    end else if (rd_start && irq_gen == '0) begin
      irq <= 1'b0;
    end else if (wr_start && addr == REG_CONTROL && !data_in[CTL_POWER_UP]) begin
      irq <= 1'b0;
    end
  end
endmodule : touch_panel_host_port_irq

// ==== shared/touch_pkg.sv ====
// Constants and types shared by the touch panel host port.
package touch_pkg;
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          REF_HZ          = 14_318_000;
  localparam int          RATE_BASE       = 35716;
  localparam int          RATE_STEP       = 4096;
  localparam logic [7:0]  RATE_RESET      = 8'h20;
  localparam logic [7:0]  RATE_MIN        = 8'h09;
  localparam int          IRQ_GEN_NS      = 100;
  localparam int          IRQ_GEN_CYCLES  = (IRQ_GEN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          CONV_CYCLES     = 64;
  localparam logic [2:0]  REG_STATUS      = 3'h0;
  localparam logic [2:0]  REG_X_LOW       = 3'h1;
  localparam logic [2:0]  REG_X_HIGH      = 3'h2;
  localparam logic [2:0]  REG_Y_LOW       = 3'h3;
  localparam logic [2:0]  REG_Y_HIGH      = 3'h4;
  localparam logic [2:0]  REG_CONTROL     = 3'h6;
  localparam logic [2:0]  REG_RATE        = 3'h7;
  localparam int          CTL_IRQ_CONV    = 0;
  localparam int          CTL_IRQ_TOUCH   = 1;
  localparam int          CTL_PERIODIC    = 2;
  localparam int          CTL_POWER_UP    = 7;
  typedef enum logic [3:0] {
    ST_SLEEP   = 4'b0001,
    ST_CONV_X  = 4'b0010,
    ST_CONV_Y  = 4'b0100,
    ST_WAIT    = 4'b1000
  } seq_state_t;
endpackage : touch_pkg

// ==== bench/touch_checker.sv ====
// Port-level assertions for the touch panel host port.
`timescale 1ns/10ps
module touch_checker
  import touch_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       chip_sel_n,
  input wire logic       rd_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       panel_touched,
  input wire logic       adc_start,
  input wire logic       drive_x,
  input wire logic       drive_y,
  input wire logic       irq,
  input wire logic       touch_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  oe_decode_a:
    assert property (data_oe == (!chip_sel_n && !rd_n)) else $error("data enable wrong");
  touch_ind_a:
    assert property (touch_n == !panel_touched) else $error("touch output wrong");
  irq_hold_a:
    assert property (irq && chip_sel_n && $past(chip_sel_n) |=> irq) else $error("irq dropped");
  irq_clear_a:
    assert property ($fell(irq) |-> !$past(chip_sel_n) || !$past(chip_sel_n, 2)) else $error("irq fell alone");
  plates_excl_a:
    assert property (!(drive_x && drive_y)) else $error("both plates driven");
  start_drive_a:
    assert property ($rose(adc_start) |-> ##[0:2] (drive_x || drive_y)) else $error("start without drive");
  start_pulse_a:
    assert property (adc_start |=> !adc_start) else $error("start not a pulse");
  // Status follows live touch and sequencer state, so every register but status must hold still.
  read_stable_a:
    assert property (data_oe && $past(data_oe) && $past(data_oe, 2) && $stable(addr) && addr == $past(addr, 2)
      && addr != REG_STATUS |-> $stable(data_out)) else $error("read data moved");
  idle_no_start_a:
    assert property (!panel_touched && !drive_x && !drive_y |=> !adc_start) else $error("start while untouched");
endmodule : touch_checker
bind touch_panel_host_port_irq touch_checker touch_checker_i (
  .sys_clk(sys_clk), .rst(rst), .chip_sel_n(chip_sel_n), .rd_n(rd_n),
  .addr({reg_addr_bit2, reg_addr_bit1, reg_addr_bit0}), .data_out(data_out), .data_oe(data_oe),
  .panel_touched(panel_touched), .adc_start(adc_start), .drive_x(drive_x), .drive_y(drive_y),
  .irq(irq), .touch_n(touch_n));

// ==== bench/touch_panel_model.sv ====
// Behavioural panel and converter that answer the plate drive.
`timescale 1ns/10ps
module touch_panel_model #(
  parameter logic [11:0] X_VAL = 12'h9c5,
  parameter logic [11:0] Y_VAL = 12'h3a7
) (
  input  wire logic        sys_clk,
  input  wire logic        drive_x,
  input  wire logic        drive_y,
  output logic      [11:0] adc_sample
);
  initial adc_sample = 12'h555;
  // Undriven plates churn, so a sample taken at the wrong time cannot match.
  always @(posedge sys_clk) begin
    if (drive_x) begin
      adc_sample <= X_VAL;
    end else if (drive_y) begin
      adc_sample <= Y_VAL;
    end else begin
      adc_sample <= ~adc_sample;
    end
  end
endmodule : touch_panel_model

// ==== bench/touch_panel_host_port_irq_bench.sv ====
// Self-checking bench for the touch panel host port.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module touch_panel_host_port_irq_bench;
  import touch_pkg::*;
  localparam logic [11:0] XV = 12'h9c5;
  localparam logic [11:0] YV = 12'h3a7;
  logic        sys_clk = 0, rst = 1, cs_n = 1, rd_n = 1, wr_n = 1, touched = 0, take = 0;
  logic [2:0]  adr = 0;
  logic [7:0]  din = 0, lf = 8'h1a, dout, exp_rd;
  logic [11:0] smp;
  logic        oe, st, dx, dy, irq, tn;
  logic [7:0]  q[$];
  int          failures = 0, n_tests = 0, ns = 0;
  touch_panel_host_port_irq #(.REF_DIV(1)) touch_panel_host_port_irq_i (
    .sys_clk(sys_clk), .rst(rst), .chip_sel_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .reg_addr_bit0(adr[0]), .reg_addr_bit1(adr[1]), .reg_addr_bit2(adr[2]), .data_in(din),
    .data_out(dout), .data_oe(oe), .panel_touched(touched), .adc_sample(smp), .adc_start(st),
    .drive_x(dx), .drive_y(dy), .irq(irq), .touch_n(tn));
  touch_panel_model #(.X_VAL(XV), .Y_VAL(YV)) touch_panel_model_i (
    .sys_clk(sys_clk), .drive_x(dx), .drive_y(dy), .adc_sample(smp));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // One strobe held for three edges; a read flags its last edge for the monitor.
  task automatic acc(input logic w, input logic c, input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cs_n <= c;
    rd_n <= w;
    wr_n <= !w;
    adr <= a;
    din <= d;
    repeat (2) @(posedge sys_clk);
    take <= !w && !c;
    @(posedge sys_clk);
    cs_n <= 1;
    rd_n <= 1;
    wr_n <= 1;
    take <= 0;
    @(posedge sys_clk);
  endtask : acc
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    q.push_back(e);
    acc(0, 0, a, 8'h00);
  endtask : rd
  task automatic tally_and_finish();
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (st === 1'b1) ns <= ns + 1;
  // The note is popped once into a variable, because the macro names its arguments twice.
  always @(posedge sys_clk) begin
    if (take) begin
      exp_rd = q.pop_front();
      `CHK(dout, exp_rd)
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 0;
    rd(REG_RATE, RATE_RESET);
    rd(REG_CONTROL, 8'h00);
    rd(REG_X_LOW, 8'h00);
    rd(REG_STATUS, 8'h00);
    acc(1, 1, REG_CONTROL, 8'h87);
    rd(REG_CONTROL, 8'h00);
    // Counts under nine are refused and land on the fastest legal rate.
    for (int i = 0; i < 4; i++) begin
      lf = (i == 3) ? 8'h03 : lfsr(lf);
      acc(1, 0, REG_RATE, lf);
      rd(REG_RATE, (lf < RATE_MIN) ? RATE_MIN : lf);
    end
    acc(1, 0, REG_CONTROL, 8'h87);
    rd(REG_CONTROL, 8'h87);
    touched <= 1;
    repeat (2) @(posedge sys_clk);
    `CHK(tn, 1'b0)
    for (int i = 0; i < 3000 && ns < 2; i++) @(posedge sys_clk);
    repeat (CONV_CYCLES + 16) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    acc(1, 0, REG_CONTROL, 8'h00);
    `CHK(irq, 1'b0)
    rd(REG_X_LOW, XV[7:0]);
    rd(REG_X_HIGH, {4'h0, XV[11:8]});
    rd(REG_Y_LOW, YV[7:0]);
    rd(REG_Y_HIGH, {4'h0, YV[11:8]});
    acc(1, 0, REG_CONTROL, 8'h87);
    for (int i = 0; i < 3000 && ns < 4; i++) @(posedge sys_clk);
    repeat (CONV_CYCLES + 16) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    rd(REG_X_LOW, XV[7:0]);
    rd(REG_Y_LOW, YV[7:0]);
    `CHK(irq, 1'b0)
    touched <= 0;
    repeat (2) @(posedge sys_clk);
    `CHK(tn, 1'b1)
    rd(REG_STATUS, 8'h00);
    tally_and_finish();
  end
endmodule : touch_panel_host_port_irq_bench
